// *** src/phsc_regs.vh ***
// Constants for the strap configuration and management register front end.
// Assumes a 10 MHz management-side clock and a synchronous, active-high reset.
`ifndef PHSC_REGS_VH
`define PHSC_REGS_VH

`define PHSC_ADDR_CTRL 5'h00
`define PHSC_ADDR_STAT 5'h01
`define PHSC_ADDR_ID1 5'h02
`define PHSC_ADDR_ID2 5'h03
`define PHSC_ADDR_ADV 5'h04
`define PHSC_ADDR_LPA 5'h05
`define PHSC_ADDR_EXP 5'h06
`define PHSC_ADDR_CIIS 5'h11
`define PHSC_ADDR_IEN 5'h12
`define PHSC_ADDR_FTX 5'h13
`define PHSC_ADDR_XMC 5'h14

`define PHSC_CTRL_RST 15
`define PHSC_CTRL_LOOP 14
`define PHSC_CTRL_SPD 13
`define PHSC_CTRL_AUTONEG_ENABLE_BIT 12
`define PHSC_CTRL_PDN 11
`define PHSC_CTRL_ISO 10
`define PHSC_CTRL_RSAN 9
`define PHSC_CTRL_DUP 8
`define PHSC_CTRL_COL 7

`define PHSC_ADV_TEN_HALF 5
`define PHSC_ADV_TEN_FULL 6
`define PHSC_ADV_FAST_HALF 7
`define PHSC_ADV_FAST_FULL 8

`define PHSC_STAT_VALUE 16'h7800
`define PHSC_ADV_SELECTOR 5'h01
`define PHSC_ADV_ABIL_DEF 4'hf
`define PHSC_FTX_NRZI 7
`define PHSC_FTX_4B5B 6
`define PHSC_FTX_NOSCR 0

`define PHSC_STRAP_SETTLE 2'h3
`define PHSC_PREAMBLE_LEN 6'h20
`define PHSC_OP_READ 2'h2
`define PHSC_OP_WRITE 2'h1

`endif

// *** src/phsc_sync.v ***
// Two-flip-flop synchroniser for a group of quasi-static inputs.
// Assumes each bit is independent; no bus coherency is implied.
`timescale 1ns/100ps
module phsc_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire reset_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk_i) begin
        if (reset_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// *** src/phsc_mdio.v ***
// Serial management frame engine: preamble, start, opcode, addresses, turnaround and data.
// Assumes mdc_i and mdio_i are already synchronised to clk_i and that mdc runs well below clk_i.
`timescale 1ns/100ps
`include "phsc_regs.vh"
module phsc_mdio (
    input wire clk_i,
    input wire reset_i,
    input wire mdc_i,
    input wire mdio_i,
    input wire [4:0] phy_addr_i,
    input wire [15:0] rd_data_i,
    output reg [4:0] reg_addr_o,
    output reg wr_o,
    output reg [15:0] wr_data_o,
    output reg mdio_o,
    output reg mdio_oe_o
);
    localparam S_PRE = 3'h0;
    localparam S_ST = 3'h1;
    localparam S_HDR = 3'h2;
    localparam S_TA = 3'h3;
    localparam S_RD = 3'h4;
    localparam S_WR = 3'h5;

    reg mdc_d_q;
    reg [2:0] state_q;
    reg [5:0] cnt_q;
    reg [11:0] hdr_q;
    reg [15:0] sh_q;
    reg is_rd_q;
    wire rise;
    wire [11:0] hdr_nx;

    assign rise = mdc_i & ~mdc_d_q;
    assign hdr_nx = {hdr_q[10:0], mdio_i};

    always @(posedge clk_i) begin
        if (reset_i) begin
            mdc_d_q <= 1'b0;
            state_q <= S_PRE;
            cnt_q <= 6'h00;
            hdr_q <= 12'h000;
            sh_q <= 16'h0000;
            is_rd_q <= 1'b0;
            reg_addr_o <= 5'h00;
            wr_o <= 1'b0;
            wr_data_o <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
        end else begin
            mdc_d_q <= mdc_i;
            wr_o <= 1'b0;
            if (rise) begin
                case (state_q)
                    S_PRE: begin
                        if (mdio_i) begin
                            if (cnt_q != `PHSC_PREAMBLE_LEN)
                                cnt_q <= cnt_q + 6'h01;
                        end else if (cnt_q == `PHSC_PREAMBLE_LEN) begin
                            state_q <= S_ST;
                        end else begin
                            cnt_q <= 6'h00;
                        end
                    end
                    S_ST: begin
                        cnt_q <= 6'h00;
                        state_q <= mdio_i ? S_HDR : S_PRE;
                    end
                    S_HDR: begin
                        hdr_q <= hdr_nx;
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'h0b) begin
                            cnt_q <= 6'h00;
                            reg_addr_o <= hdr_nx[4:0];
                            is_rd_q <= (hdr_nx[11:10] == `PHSC_OP_READ);
                            // Frames for another address are let pass
                            if (hdr_nx[9:5] == phy_addr_i &&
                                (hdr_nx[11:10] == `PHSC_OP_READ || hdr_nx[11:10] == `PHSC_OP_WRITE))
                                state_q <= S_TA;
                            else
                                state_q <= S_PRE;
                        end
                    end
                    S_TA: begin
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'h00) begin
                            if (is_rd_q) begin
                                mdio_oe_o <= 1'b1;
                                mdio_o <= 1'b0;
                                sh_q <= rd_data_i;
                            end
                        end else begin
                            cnt_q <= 6'h00;
                            if (is_rd_q) begin
                                mdio_o <= sh_q[15];
                                sh_q <= {sh_q[14:0], 1'b0};
                                state_q <= S_RD;
                            end else begin
                                state_q <= S_WR;
                            end
                        end
                    end
                    S_RD: begin
                        cnt_q <= cnt_q + 6'h01;
                        mdio_o <= sh_q[15];
                        sh_q <= {sh_q[14:0], 1'b0};
                        if (cnt_q == 6'h0f) begin
                            mdio_oe_o <= 1'b0;
                            mdio_o <= 1'b0;
                            cnt_q <= 6'h00;
                            state_q <= S_PRE;
                        end
                    end
                    S_WR: begin
                        cnt_q <= cnt_q + 6'h01;
                        sh_q <= {sh_q[14:0], mdio_i};
                        if (cnt_q == 6'h0f) begin
                            wr_o <= 1'b1;
                            wr_data_o <= {sh_q[14:0], mdio_i};
                            cnt_q <= 6'h00;
                            state_q <= S_PRE;
                        end
                    end
                    default: begin
                        state_q <= S_PRE;
                        cnt_q <= 6'h00;
                    end
                endcase
            end
        end
    end
endmodule

// *** src/phsc_top.v ***
// Strap capture, management register bank and LED polarity for the transceiver.
// Assumes straps and management pins are asynchronous; LED states come from logic on clk_i.
`timescale 1ns/100ps
`include "phsc_regs.vh"
module phsc_top #(
    parameter [15:0] ID_UPPER = 16'h1234,
    parameter [15:0] ID_LOWER = 16'h5678
) (
    input wire clk_i,
    input wire reset_i,
    input wire [4:0] mode_strap_pins_i,
    input wire [1:0] advert_select_pins_i,
    input wire full_duplex_strap_i,
    input wire [4:0] phy_addr_straps_i,
    input wire mdc_i,
    input wire mdio_i,
    output wire mdio_o,
    output wire mdio_oe_o,
    input wire [4:0] led_state_i,
    output reg [4:0] led_o,
    output reg [4:0] phy_addr_o,
    output reg loopback_o,
    output reg speed_100_o,
    output reg autoneg_en_o,
    output reg full_duplex_o,
    output reg isolate_o,
    output reg power_down_o,
    output reg restart_an_o,
    output reg collision_test_o,
    output reg dev_reset_o
);
    // ID_UPPER and ID_LOWER values are arbitrary.

    wire [12:0] straps_s;
    wire [4:0] mode_s;
    wire [1:0] sel_s;
    wire fde_s;
    wire [4:0] pad_s;
    wire [1:0] mgmt_s;
    wire [4:0] reg_addr;
    wire wr;
    wire [15:0] wr_data;

    reg [1:0] settle_q;
    reg busy_q;
    reg soft_rst_q;
    reg loop_q;
    reg speed_select_bit_q;
    reg autoneg_enable_bit_q;
    reg pdn_q;
    reg iso_q;
    reg rsan_q;
    reg dup_q;
    reg col_q;
    reg an_strap_q;
    reg [10:0] adv_q;
    reg [15:0] ien_q;
    reg [15:0] ftx_q;
    reg [15:0] xmc_q;
    reg [4:0] addr_q;
    reg [4:0] led_pol_q;
    reg [15:0] rd_data;
    reg [15:0] ctrl_val;
    reg [15:0] adv_val;
    reg [3:0] abil;

    phsc_sync #(
        .WIDTH(13)
    ) u_strap_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({mode_strap_pins_i, advert_select_pins_i, full_duplex_strap_i, phy_addr_straps_i}),
        .sync_o(straps_s)
    );

    phsc_sync #(
        .WIDTH(2)
    ) u_mgmt_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({mdc_i, mdio_i}),
        .sync_o(mgmt_s)
    );

    assign mode_s = straps_s[12:8];
    assign sel_s = straps_s[7:6];
    assign fde_s = straps_s[5];
    assign pad_s = straps_s[4:0];

    phsc_mdio u_mdio (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .mdc_i(mgmt_s[1]),
        .mdio_i(mgmt_s[0]),
        .phy_addr_i(addr_q),
        .rd_data_i(rd_data),
        .reg_addr_o(reg_addr),
        .wr_o(wr),
        .wr_data_o(wr_data),
        .mdio_o(mdio_o),
        .mdio_oe_o(mdio_oe_o)
    );

    // Advertised abilities from the straps, fast-full down to ten-half.
    always @* begin
        abil[`PHSC_ADV_FAST_HALF - 5] = sel_s[0];
        abil[`PHSC_ADV_TEN_HALF - 5] = sel_s[1];
        abil[`PHSC_ADV_FAST_FULL - 5] = sel_s[0] & fde_s;
        abil[`PHSC_ADV_TEN_FULL - 5] = sel_s[1] & fde_s;
    end

    always @* begin
        ctrl_val = {soft_rst_q, loop_q, speed_select_bit_q, autoneg_enable_bit_q, pdn_q, iso_q, rsan_q, dup_q, col_q, 7'h00};
        adv_val = {adv_q, `PHSC_ADV_SELECTOR};
        // Default abilities whenever negotiation is off
        if (!an_strap_q || !autoneg_enable_bit_q)
            adv_val[8:5] = `PHSC_ADV_ABIL_DEF;
    end

    // Read decode
    always @* begin
        case (reg_addr)
            `PHSC_ADDR_CTRL: rd_data = ctrl_val;
            `PHSC_ADDR_STAT: rd_data = `PHSC_STAT_VALUE;
            `PHSC_ADDR_ID1: rd_data = ID_UPPER;
            `PHSC_ADDR_ID2: rd_data = ID_LOWER;
            `PHSC_ADDR_ADV: rd_data = adv_val;
            `PHSC_ADDR_LPA: rd_data = 16'h0000;
            `PHSC_ADDR_EXP: rd_data = 16'h0000;
            `PHSC_ADDR_CIIS: rd_data = 16'h0000;
            `PHSC_ADDR_IEN: rd_data = ien_q;
            `PHSC_ADDR_FTX: rd_data = ftx_q;
            `PHSC_ADDR_XMC: rd_data = xmc_q;
            default: rd_data = 16'h0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            settle_q <= 2'h0;
            busy_q <= 1'b1;
            soft_rst_q <= 1'b0;
            loop_q <= 1'b0;
            speed_select_bit_q <= 1'b1;
            autoneg_enable_bit_q <= 1'b1;
            pdn_q <= 1'b0;
            iso_q <= 1'b0;
            rsan_q <= 1'b0;
            dup_q <= 1'b0;
            col_q <= 1'b0;
            an_strap_q <= 1'b1;
            adv_q <= 11'h000;
            ien_q <= 16'h0000;
            ftx_q <= 16'h0000;
            xmc_q <= 16'h0000;
            addr_q <= 5'h00;
            led_pol_q <= 5'h00;
        end else if (busy_q) begin
            // Straps are captured once the synchronisers hold settled values
            settle_q <= settle_q + 2'h1;
            if (settle_q == `PHSC_STRAP_SETTLE) begin
                busy_q <= 1'b0;
                soft_rst_q <= 1'b0;
                loop_q <= 1'b0;
                an_strap_q <= mode_s[0];
                autoneg_enable_bit_q <= mode_s[0];
                speed_select_bit_q <= mode_s[4];
                dup_q <= mode_s[0] ? 1'b0 : fde_s;
                pdn_q <= 1'b0;
                rsan_q <= 1'b0;
                col_q <= 1'b0;
                iso_q <= (pad_s == 5'h00);
                addr_q <= pad_s;
                led_pol_q <= pad_s;
                adv_q <= 11'h000;
                // Strap-derived abilities
                adv_q[3:0] <= mode_s[0] ? abil : `PHSC_ADV_ABIL_DEF;
                ien_q <= 16'h0000;
                xmc_q <= 16'h0000;
                ftx_q <= 16'h0000;
                ftx_q[`PHSC_FTX_NRZI] <= mode_s[1];
                ftx_q[`PHSC_FTX_4B5B] <= mode_s[2];
                ftx_q[`PHSC_FTX_NOSCR] <= mode_s[3];
            end
        end else begin
            rsan_q <= 1'b0;
            if (wr) begin
                case (reg_addr)
                    `PHSC_ADDR_CTRL: begin
                        if (wr_data[`PHSC_CTRL_RST]) begin
                            // Self-clearing device reset
                            soft_rst_q <= 1'b1;
                            busy_q <= 1'b1;
                            settle_q <= 2'h0;
                        end
                        loop_q <= wr_data[`PHSC_CTRL_LOOP];
                        speed_select_bit_q <= wr_data[`PHSC_CTRL_SPD];
                        autoneg_enable_bit_q <= wr_data[`PHSC_CTRL_AUTONEG_ENABLE_BIT];
                        pdn_q <= wr_data[`PHSC_CTRL_PDN];
                        iso_q <= wr_data[`PHSC_CTRL_ISO];
                        rsan_q <= wr_data[`PHSC_CTRL_RSAN];
                        dup_q <= wr_data[`PHSC_CTRL_DUP];
                        col_q <= wr_data[`PHSC_CTRL_COL];
                    end
                    `PHSC_ADDR_ADV: adv_q <= wr_data[15:5];
                    `PHSC_ADDR_IEN: ien_q <= wr_data;
                    `PHSC_ADDR_FTX: ftx_q <= wr_data;
                    `PHSC_ADDR_XMC: xmc_q <= wr_data;
                    default: ien_q <= ien_q;
                endcase
            end
        end
    end

    // Registered copies of the control state for the rest of the transceiver.
    always @(posedge clk_i) begin
        if (reset_i) begin
            led_o <= 5'h00;
            phy_addr_o <= 5'h00;
            loopback_o <= 1'b0;
            speed_100_o <= 1'b1;
            autoneg_en_o <= 1'b1;
            full_duplex_o <= 1'b0;
            isolate_o <= 1'b0;
            power_down_o <= 1'b0;
            restart_an_o <= 1'b0;
            collision_test_o <= 1'b0;
            dev_reset_o <= 1'b1;
        end else begin
            led_o <= led_state_i ^ led_pol_q;
            phy_addr_o <= addr_q;
            loopback_o <= loop_q;
            speed_100_o <= speed_select_bit_q;
            autoneg_en_o <= autoneg_enable_bit_q;
            full_duplex_o <= dup_q;
            isolate_o <= iso_q;
            power_down_o <= pdn_q;
            restart_an_o <= rsan_q;
            collision_test_o <= col_q;
            dev_reset_o <= busy_q;
        end
    end
endmodule

// *** verif/phsc_top_checker.sv ***
// Concurrent checks on the strap capture and management answer of phsc_top.
// Assumes one clock domain on clk_i with a synchronous active-high reset_i.
`timescale 1ns/100ps
module phsc_top_checker (
    input wire clk_i,
    input wire reset_i,
    input wire [4:0] mode_strap_pins_i,
    input wire full_duplex_strap_i,
    input wire [4:0] phy_addr_straps_i,
    input wire mdc_i,
    input wire mdio_o,
    input wire mdio_oe_o,
    input wire [4:0] led_state_i,
    input wire [4:0] led_o,
    input wire [4:0] phy_addr_o,
    input wire loopback_o,
    input wire speed_100_o,
    input wire autoneg_en_o,
    input wire full_duplex_o,
    input wire isolate_o,
    input wire restart_an_o,
    input wire dev_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    reg mdc_q;
    reg [4:0] rise_cnt_q;
    // Counts management clock rises while the device drives the data line.
    always @(posedge clk_i) begin
        mdc_q <= mdc_i;
        if (reset_i || !mdio_oe_o) begin
            rise_cnt_q <= 5'h00;
        end else if (mdc_i && !mdc_q) begin
            rise_cnt_q <= rise_cnt_q + 5'h01;
        end
    end
    sequence s_ready;
        $fell(dev_reset_o);
    endsequence
    sequence s_drive;
        !mdio_o ##1 mdio_oe_o [*8];
    endsequence
    property p_reset_out;
        $fell(reset_i) |-> dev_reset_o && speed_100_o && autoneg_en_o && !loopback_o && !mdio_oe_o;
    endproperty
    property p_reset_len;
        $fell(reset_i) || $rose(dev_reset_o) |-> ##[1:10] !dev_reset_o;
    endproperty
    property p_an_seed;
        s_ready |-> autoneg_en_o == mode_strap_pins_i[0];
    endproperty
    property p_spd_seed;
        s_ready |-> speed_100_o == mode_strap_pins_i[4];
    endproperty
    property p_dup_seed;
        s_ready |-> full_duplex_o == (full_duplex_strap_i && !mode_strap_pins_i[0]);
    endproperty
    property p_addr_seed;
        s_ready |-> phy_addr_o == phy_addr_straps_i && isolate_o == (phy_addr_straps_i == 5'h00);
    endproperty
    property p_addr_hold;
        !dev_reset_o && !$past(dev_reset_o) |-> $stable(phy_addr_o);
    endproperty
    property p_led;
        !dev_reset_o && !$past(dev_reset_o) |-> led_o == ($past(led_state_i) ^ phy_addr_o);
    endproperty
    property p_turn;
        $rose(mdio_oe_o) |-> s_drive;
    endproperty
    property p_read_len;
        $fell(mdio_oe_o) |-> rise_cnt_q == 5'h11;
    endproperty
    property p_rsan_pulse;
        restart_an_o |=> !restart_an_o;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
    a_reset_len: assert property (p_reset_len) else $error("device reset too long");
    a_an_seed: assert property (p_an_seed) else $error("negotiation enable not seeded");
    a_spd_seed: assert property (p_spd_seed) else $error("speed not seeded");
    a_dup_seed: assert property (p_dup_seed) else $error("duplex not seeded");
    a_addr_seed: assert property (p_addr_seed) else $error("address or isolate not seeded");
    a_addr_hold: assert property (p_addr_hold) else $error("address changed after capture");
    a_led: assert property (p_led) else $error("LED polarity wrong");
    a_turn: assert property (p_turn) else $error("turnaround not driven low");
    a_read_len: assert property (p_read_len) else $error("read data length wrong");
    a_rsan_pulse: assert property (p_rsan_pulse) else $error("restart request held too long");
endmodule

bind phsc_top phsc_top_checker u_checker (
    .clk_i(clk_i), .reset_i(reset_i), .mode_strap_pins_i(mode_strap_pins_i),
    .full_duplex_strap_i(full_duplex_strap_i), .phy_addr_straps_i(phy_addr_straps_i), .mdc_i(mdc_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .led_state_i(led_state_i), .led_o(led_o),
    .phy_addr_o(phy_addr_o), .loopback_o(loopback_o), .speed_100_o(speed_100_o),
    .autoneg_en_o(autoneg_en_o), .full_duplex_o(full_duplex_o), .isolate_o(isolate_o),
    .restart_an_o(restart_an_o),
    .dev_reset_o(dev_reset_o)
);

// *** verif/phsc_mgmt_model.sv ***
// Station management controller model driving the serial management pins.
// Assumes a pull-up on the data line and a device sampling on rising mdc.
`timescale 1ns/100ps
`include "phsc_regs.vh"
module phsc_mgmt_model (
    input wire clk_i,
    input wire dev_mdio_i,
    input wire dev_oe_i,
    output reg mdc_o,
    output wire mdio_o
);
    reg drv_q = 1'b0;
    reg val_q = 1'b1;
    reg seen_q = 1'b0;
    // The released line floats to the pull-up level.
    assign mdio_o = dev_oe_i ? dev_mdio_i : (drv_q ? val_q : 1'b1);
    initial mdc_o = 1'b0;
    task bit_cyc(input drive, input val, output smp);
        begin
            @(posedge clk_i);
            mdc_o <= 1'b0;
            drv_q <= drive;
            val_q <= val;
            repeat (8) @(posedge clk_i);
            mdc_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            @(negedge clk_i);
            smp = mdio_o;
            seen_q = seen_q | dev_oe_i;
        end
    endtask
    task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd, output [15:0] rd,
               output drove);
        reg [63:0] pat;
        reg s;
        integer i;
        begin
            seen_q = 1'b0;
            rd = 16'h0000;
            pat = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
            for (i = 63; i >= 0; i = i - 1) begin
                bit_cyc(op == `PHSC_OP_WRITE || i > 17, pat[i], s);
                if (i >= 1 && i <= 16) rd[i-1] = s;
            end
            @(posedge clk_i);
            mdc_o <= 1'b0;
            drv_q <= 1'b0;
            repeat (8) @(posedge clk_i);
            drove = seen_q;
        end
    endtask
endmodule

// *** verif/phy_strap_config_and_control_bench.sv ***
// Self-checking bench for strap capture and the management register bank.
// Assumes the controller model above and the checker bound to phsc_top.
`timescale 1ns/100ps
`include "phsc_regs.vh"
module phy_strap_config_and_control_bench;
    localparam [15:0] ID_HI = 16'h0abc; // Arbitrary identifier value.
    reg clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [4:0] mode_q = 5'h11;
    reg [1:0] adv_q = 2'b01;
    reg fd_q = 1'b1;
    reg [4:0] addr_q = 5'h05;
    reg [4:0] led_q = 5'h13;
    wire mdc, mdio_line, mdio_dev, mdio_oe, loopback, speed_100, autoneg_en, full_duplex, isolate, dev_reset;
    wire power_down, collision;
    wire [4:0] led;
    wire [4:0] phy_addr;
    reg [15:0] rd;
    reg drove;
    integer num_errors = 0;
    integer n_compared = 0;
    integer i;
    always #50 clk_i = ~clk_i;
    phsc_top #(.ID_UPPER(ID_HI), .ID_LOWER(16'h0def)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .mode_strap_pins_i(mode_q), .advert_select_pins_i(adv_q),
        .full_duplex_strap_i(fd_q), .phy_addr_straps_i(addr_q), .mdc_i(mdc), .mdio_i(mdio_line),
        .mdio_o(mdio_dev), .mdio_oe_o(mdio_oe), .led_state_i(led_q), .led_o(led), .phy_addr_o(phy_addr),
        .loopback_o(loopback), .speed_100_o(speed_100), .autoneg_en_o(autoneg_en), .full_duplex_o(full_duplex),
        .isolate_o(isolate), .power_down_o(power_down), .restart_an_o(), .collision_test_o(collision),
        .dev_reset_o(dev_reset)
    );
    phsc_mgmt_model mgmt (
        .clk_i(clk_i), .dev_mdio_i(mdio_dev), .dev_oe_i(mdio_oe), .mdc_o(mdc), .mdio_o(mdio_line)
    );
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [8*10-1:0] what, input [15:0] exp, input [15:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wait_ready;
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            while (dev_reset !== 1'b0 && n < 50) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n >= 50) begin
                chk("ready", 16'h0000, 16'h0001);
                final_report;
            end
        end
    endtask
    task hw_reset(input [4:0] mode, input [1:0] adv, input fd, input [4:0] addr);
        begin
            @(posedge clk_i);
            mode_q <= mode;
            adv_q <= adv;
            fd_q <= fd;
            addr_q <= addr;
            reset_i <= 1'b1;
            repeat (10) @(posedge clk_i);
            reset_i <= 1'b0;
            wait_ready;
        end
    endtask
    task rd_reg(input [4:0] pa, input [4:0] ra);
        mgmt.frame(`PHSC_OP_READ, pa, ra, 16'hffff, rd, drove);
    endtask
    task wr_reg(input [4:0] pa, input [4:0] ra, input [15:0] d);
        mgmt.frame(`PHSC_OP_WRITE, pa, ra, d, rd, drove);
    endtask
    task t_defaults;
        begin
            hw_reset(5'h1f, 2'b01, 1'b1, 5'h05);
            rd_reg(5'h05, `PHSC_ADDR_CTRL);
            chk("ctrl", 16'h3000, rd);
            chk("drove", 16'h0001, drove);
            rd_reg(5'h05, `PHSC_ADDR_FTX);
            chk("fast_tx", 16'h00c1, rd);
            rd_reg(5'h05, `PHSC_ADDR_ADV);
            chk("advert", 16'h0181, rd);
            rd_reg(5'h05, `PHSC_ADDR_STAT);
            chk("status", 16'h7800, rd);
            rd_reg(5'h05, `PHSC_ADDR_ID1);
            chk("ident", ID_HI, rd);
            rd_reg(5'h05, 5'h07);
            chk("unmapped", 16'h0000, rd);
            chk("phy_addr", 16'h0005, phy_addr);
            chk("led", 16'h0016, led);
        end
    endtask
    task t_advert;
        reg [3:0] ab;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                hw_reset(5'h11, i[1:0], i[2], 5'h05);
                ab = {i[0] & i[2], i[0], i[1] & i[2], i[1]};
                rd_reg(5'h05, `PHSC_ADDR_ADV);
                chk("advert", {7'h00, ab, 5'h01}, rd);
            end
        end
    endtask
    task t_control;
        begin
            hw_reset(5'h11, 2'b01, 1'b0, 5'h05);
            wr_reg(5'h05, `PHSC_ADDR_CTRL, 16'h4a80);
            rd_reg(5'h05, `PHSC_ADDR_CTRL);
            chk("ctrl", 16'h4880, rd);
            chk("loopback", 16'h0001, loopback);
            chk("power_down", 16'h0001, power_down);
            chk("collision", 16'h0001, collision);
            chk("autoneg", 16'h0000, autoneg_en);
            chk("speed", 16'h0000, speed_100);
            rd_reg(5'h05, `PHSC_ADDR_ADV);
            chk("advert", 16'h01e1, rd);
        end
    endtask
    task t_strap_low;
        begin
            hw_reset(5'h00, 2'b01, 1'b1, 5'h05);
            rd_reg(5'h05, `PHSC_ADDR_CTRL);
            chk("ctrl", 16'h0100, rd);
            chk("duplex", 16'h0001, full_duplex);
            rd_reg(5'h05, `PHSC_ADDR_ADV);
            chk("advert", 16'h01e1, rd);
        end
    endtask
    task t_address;
        begin
            hw_reset(5'h11, 2'b01, 1'b1, 5'h05);
            wr_reg(5'h06, `PHSC_ADDR_CTRL, 16'h4000);
            rd_reg(5'h06, `PHSC_ADDR_CTRL);
            chk("foreign", 16'hffff, rd);
            chk("drove", 16'h0000, drove);
            rd_reg(5'h05, `PHSC_ADDR_CTRL);
            chk("ctrl", 16'h3000, rd);
        end
    endtask
    task t_soft_reset;
        begin
            @(posedge clk_i);
            addr_q <= 5'h00;
            led_q <= 5'h0e;
            wr_reg(5'h05, `PHSC_ADDR_CTRL, 16'h4000);
            chk("phy_addr", 16'h0005, phy_addr);
            wr_reg(5'h05, `PHSC_ADDR_CTRL, 16'hc000);
            wait_ready;
            chk("phy_addr", 16'h0000, phy_addr);
            chk("isolate", 16'h0001, isolate);
            rd_reg(5'h00, `PHSC_ADDR_CTRL);
            chk("ctrl", 16'h3400, rd);
            chk("led", 16'h000e, led);
        end
    endtask
    task t_regs;
        begin
            wr_reg(5'h00, `PHSC_ADDR_IEN, 16'ha5c3);
            rd_reg(5'h00, `PHSC_ADDR_IEN);
            chk("irq_en", 16'ha5c3, rd);
            wr_reg(5'h00, 5'h07, 16'hffff);
            rd_reg(5'h00, 5'h07);
            chk("unmapped", 16'h0000, rd);
            wr_reg(5'h00, `PHSC_ADDR_STAT, 16'hffff);
            rd_reg(5'h00, `PHSC_ADDR_STAT);
            chk("status", 16'h7800, rd);
        end
    endtask
    initial begin
        t_defaults;
        t_advert;
        t_control;
        t_strap_low;
        t_address;
        t_soft_reset;
        t_regs;
        final_report;
    end
endmodule
